// ===== logic/spf_consts.svh
// Constants of the self-programming flash controller: offsets, fields, counts.
// Assumes inclusion by bare name from the package and the controller module.
//
// Functional notes
// R1 - Ready interrupt is held while its enable and global enable are set, store enable clear.
// R2 - Erase or write into the read-while-write section sets the busy flag; access blocked.
// R3 - Busy flag clears on a re-enable after completion, or when a buffer load starts.
// R4 - Re-enable armed with store enable reopens the section; refused during erase/write.
// R5 - Writing re-enable while the buffer holds loaded words aborts and discards the load.
// R6 - Lock-set armed: next store within four cycles programs boot lock bits from R0.
// R7 - Lock-set clears on completion or when no store follows within four cycles.
// R8 - Load within three cycles of lock-set arming returns lock or fuse bits per pointer.
// R9 - Page write armed: next store writes the buffer into the page in upper pointer bits.
// R10 - Page write bit clears on completion or when no store follows within four cycles.
// R11 - Page erase armed: next store erases the page in upper pointer bits.
// R12 - Page erase bit clears on completion or when no store follows within four cycles.
// R13 - Erase or write into the no-read-while-write section halts the processor throughout.
// R14 - Store enable alone: next store puts R1:R0 into buffer word from pointer bits 7:1.
// R15 - Store enable opens four cycles, clears after store or expiry, held during erase/write.
// R16 - Any lower-five-bit value other than the five legal commands has no effect.
// R17 - Page select from pointer bits 15:8, buffer word from bits 7:1; bit 0 unused.
// R18 - A page holds 128 words; software keeps word select zero for a page write.
// R19 - Two boot-size bits pick boot start 0x7E00, 0x7C00, 0x7800 or 0x7000.
// R20 - Words 0x0000-0x6FFF form the read-while-write section, 0x7000-0x7FFF the other.
// R21 - Word address is a 15-bit counter; its top bit maps to pointer bit 15.
// R22 - Each erase, write or lock programming lasts between 3.7 ms and 4.5 ms.
// R23 - A data-memory write in progress blocks self-programming and fuse or lock readout.
// R24 - Busy flag is read-only; writes to it and to bit 5 are ignored.
`ifndef SPF_CONSTS_SVH
`define SPF_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SPF_ADDR_W        12
`define SPF_CTRL_ADDR     12'h068
`define SPF_CTRL_RESET    8'h00
`define SPF_RESP_OKAY     2'b00
`define SPF_RESP_SLVERR   2'b10
`define SPF_BIT_IRQ_EN    7
`define SPF_BIT_BUSY      6

// ----------------------------------------------------------------
// Command codes in the low five bits
// ----------------------------------------------------------------
`define SPF_CMD_NONE      5'h00
`define SPF_CMD_STORE     5'h01
`define SPF_CMD_ERASE     5'h03
`define SPF_CMD_WRITE     5'h05
`define SPF_CMD_LOCK      5'h09
`define SPF_CMD_REEN      5'h11

// ----------------------------------------------------------------
// Windows, geometry, values
// ----------------------------------------------------------------
`define SPF_ARM_WINDOW    3'h4
`define SPF_LPM_LAST_CNT  3'h2
`define SPF_PAGE_WORDS    128
`define SPF_NO_READ_WHILE_WRITE_SECTION_PAGE     8'he0
`define SPF_BOOT_512      15'h7e00
`define SPF_BOOT_1024     15'h7c00
`define SPF_BOOT_2048     15'h7800
`define SPF_BOOT_4096     15'h7000
`define SPF_LOCK_RESET    8'hff
`define SPF_Z_FUSE_LO     2'h0
`define SPF_Z_LOCK        2'h1
`define SPF_Z_FUSE_EXT    2'h2
`define SPF_Z_FUSE_HI     2'h3

// ----------------------------------------------------------------
// Programming time
// ----------------------------------------------------------------
`define SPF_CLK_PERIOD_NS 25
`define SPF_PROG_MIN_NS   3700000
`define SPF_PROG_MAX_NS   4500000
`define SPF_PROG_MIN_CYC  ((`SPF_PROG_MIN_NS + `SPF_CLK_PERIOD_NS - 1) / `SPF_CLK_PERIOD_NS)
`define SPF_PROG_MAX_CYC  (`SPF_PROG_MAX_NS / `SPF_CLK_PERIOD_NS)
`define SPF_OP_CNT_W      20

`endif

// ===== logic/spf_pkg.sv
// Types of the self-programming flash controller.
// Assumes spf_consts.svh sits on the include path.
`include "spf_consts.svh"

package spf_pkg;

  typedef enum logic [1:0] {
    SPF_IDLE  = 2'b00,
    SPF_ARMED = 2'b01,
    SPF_RUN   = 2'b10
  } spf_phase_t;

  typedef enum logic [1:0] {
    SPF_OP_NONE  = 2'b00,
    SPF_OP_ERASE = 2'b01,
    SPF_OP_WRITE = 2'b10,
    SPF_OP_LOCK  = 2'b11
  } spf_op_t;

  typedef struct packed {
    logic [`SPF_PAGE_WORDS-1:0][15:0] buf_mem;
    spf_phase_t                        phase;
    spf_op_t                           op;
    logic [2:0]                        arm_cnt;
    logic [4:0]                        cmd;
    logic [`SPF_OP_CNT_W-1:0]          op_cnt;
    logic                              irq_en;
    logic                              rww_busy;
    logic                              halt;
    logic                              buf_loaded;
    logic [7:0]                        page;
    logic [7:0]                        lock_bits;
    logic [7:0]                        lock_data;
    logic [7:0]                        lpm_data;
    logic                              lpm_valid;
    logic                              irq;
    logic [14:0]                       boot_start;
    logic                              erase_pulse;
    logic                              write_pulse;
    logic                              lock_pulse;
    logic [15:0]                       buf_word;
    logic                              aw_got;
    logic                              w_got;
    logic [`SPF_ADDR_W-1:0]            awaddr;
    logic [31:0]                       wdata;
    logic [3:0]                        wstrb;
    logic                              bvalid;
    logic [1:0]                        bresp;
    logic                              rvalid;
    logic [31:0]                       rdata;
    logic [1:0]                        rresp;
  } spf_state_t;

endpackage

// ===== logic/spf_ctrl.sv
// Self-programming flash controller: control register on AXI4-Lite, store and
// load strobes from the core, page buffer, timed erase/write/lock operations.
// Assumes the core strobes are synchronous one-cycle pulses and the flash array
// performs the operation signalled by the start pulses.
`timescale 1ns/1ps
`include "spf_consts.svh"

module spf_ctrl #(
  parameter int PROG_CYCLES = `SPF_PROG_MIN_CYC
) (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite slave
  input  wire logic [`SPF_ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [`SPF_ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Core side
  input  wire logic                      spm_strobe,
  input  wire logic                      lpm_strobe,
  input  wire logic [15:0]               z_ptr,
  input  wire logic [7:0]                r0_data,
  input  wire logic [7:0]                r1_data,
  input  wire logic                      global_irq_enable,
  input  wire logic                      nvdata_write_busy,
  output logic                           lpm_special_valid,
  output logic [7:0]                     lpm_special_data,
  output logic                           ready_irq,
  output logic                           cpu_halt,
  output logic                           rw_section_busy,
  // Configuration
  input  wire logic                      boot_size_hi,
  input  wire logic                      boot_size_lo,
  input  wire logic [7:0]                fuse_low,
  input  wire logic [7:0]                fuse_high,
  input  wire logic [7:0]                fuse_ext,
  output logic [14:0]                    boot_start_addr,
  output logic [7:0]                     lock_bits,
  // Flash array side
  output logic                           flash_erase_start,
  output logic                           flash_write_start,
  output logic                           flash_lock_start,
  output logic [7:0]                     flash_page,
  output logic [7:0]                     flash_lock_data,
  input  wire logic [6:0]                flash_buf_index,
  output logic [15:0]                    flash_buf_word
);
  import spf_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic cmd_legal(input logic [4:0] c);
    case (c)
      `SPF_CMD_STORE, `SPF_CMD_REEN, `SPF_CMD_LOCK,
      `SPF_CMD_WRITE, `SPF_CMD_ERASE: cmd_legal = 1'b1;
      default:                        cmd_legal = 1'b0;
    endcase
  endfunction

  function automatic logic [14:0] boot_start_of(input logic hi, input logic lo);
    case ({hi, lo})
      2'b11:   boot_start_of = `SPF_BOOT_512;
      2'b10:   boot_start_of = `SPF_BOOT_1024;
      2'b01:   boot_start_of = `SPF_BOOT_2048;
      default: boot_start_of = `SPF_BOOT_4096;
    endcase
  endfunction

  spf_state_t q;
  spf_state_t s;
  logic       ctrl_wr;
  logic       spm_go;
  logic       lpm_go;
  logic [7:0] ctrl_byte;
  logic [7:0] lock_view;

  // ----------------------------------------------------------------
  // Decode shared by logic and checks
  // ----------------------------------------------------------------
  assign ctrl_wr   = q.aw_got && q.w_got && !q.bvalid && q.wstrb[0] &&
                     (q.awaddr[`SPF_ADDR_W-1:2] == `SPF_CTRL_ADDR >> 2);
  // Data-memory write blocks every store and load special [R23]
  assign spm_go    = spm_strobe && (q.phase == SPF_ARMED) && !nvdata_write_busy;
  assign lpm_go    = lpm_strobe && (q.phase == SPF_ARMED) && (q.cmd == `SPF_CMD_LOCK) &&
                     (q.arm_cnt >= `SPF_LPM_LAST_CNT) && !nvdata_write_busy;
  // Bit 5 reads zero [R24]
  assign ctrl_byte = {q.irq_en, q.rww_busy, 1'b0, q.cmd};
  assign lock_view = {2'b11, q.lock_bits[5:2], 2'b11};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s             = q;
    s.erase_pulse = 1'b0;
    s.write_pulse = 1'b0;
    s.lock_pulse  = 1'b0;
    s.lpm_valid   = 1'b0;

    // Bus write: address and data in either order, response after both
    if (s_axi_awvalid && s_axi_awready) begin
      s.aw_got = 1'b1;
      s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s.w_got = 1'b1;
      s.wdata = s_axi_wdata;
      s.wstrb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      s.aw_got = 1'b0;
      s.w_got  = 1'b0;
      s.bvalid = 1'b1;
      s.bresp  = (q.awaddr[`SPF_ADDR_W-1:2] == `SPF_CTRL_ADDR >> 2) ? `SPF_RESP_OKAY : `SPF_RESP_SLVERR;
    end
    if (q.bvalid && s_axi_bready) begin
      s.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s.rvalid = 1'b1;
      if (s_axi_araddr[`SPF_ADDR_W-1:2] == `SPF_CTRL_ADDR >> 2) begin
        s.rdata = {24'h000000, ctrl_byte};
        s.rresp = `SPF_RESP_OKAY;
      end else begin
        s.rdata = 32'h00000000;
        s.rresp = `SPF_RESP_SLVERR;
      end
    end
    if (q.rvalid && s_axi_rready) begin
      s.rvalid = 1'b0;
    end

    // Command sequencer
    case (q.phase)
      SPF_ARMED: begin
        if (spm_go) begin
          case (q.cmd)
            `SPF_CMD_STORE: begin
              // Pointer bit 0 ignored, word from bits 7:1 [R14] [R17]
              s.buf_mem[z_ptr[7:1]] = {r1_data, r0_data};
              s.rww_busy            = 1'b0; // [R3]
              s.buf_loaded          = 1'b1;
              s.cmd                 = `SPF_CMD_NONE; // [R15]
              s.phase               = SPF_IDLE;
            end
            `SPF_CMD_REEN: begin
              s.rww_busy = 1'b0; // [R3] [R4]
              s.cmd      = `SPF_CMD_NONE;
              s.phase    = SPF_IDLE;
            end
            `SPF_CMD_LOCK: begin
              // R1 and pointer ignored [R6]
              s.op         = SPF_OP_LOCK;
              s.lock_data  = r0_data;
              s.lock_pulse = 1'b1;
              s.op_cnt     = PROG_CYCLES[`SPF_OP_CNT_W-1:0]; // [R22]
              s.phase      = SPF_RUN;
            end
            default: begin
              // Page from pointer bits 15:8, a 15-bit word address [R9] [R11] [R17] [R21]
              s.page        = z_ptr[15:8];
              s.op          = (q.cmd == `SPF_CMD_WRITE) ? SPF_OP_WRITE : SPF_OP_ERASE;
              s.write_pulse = (q.cmd == `SPF_CMD_WRITE);
              s.erase_pulse = (q.cmd == `SPF_CMD_ERASE);
              // Section split at page 224 [R20]
              if (z_ptr[15:8] < `SPF_NO_READ_WHILE_WRITE_SECTION_PAGE) begin
                s.rww_busy = 1'b1; // [R2]
              end else begin
                s.halt     = 1'b1; // [R13]
              end
              s.op_cnt      = PROG_CYCLES[`SPF_OP_CNT_W-1:0]; // [R22]
              s.phase       = SPF_RUN;
            end
          endcase
        end else if (lpm_go) begin
          // Pointer low bits pick lock or fuse byte [R8]
          case (z_ptr[1:0])
            `SPF_Z_LOCK:     s.lpm_data = lock_view;
            `SPF_Z_FUSE_HI:  s.lpm_data = fuse_high;
            `SPF_Z_FUSE_EXT: s.lpm_data = fuse_ext;
            default:         s.lpm_data = fuse_low;
          endcase
          s.lpm_valid = 1'b1;
          s.cmd       = `SPF_CMD_NONE;
          s.phase     = SPF_IDLE;
        end else if (q.arm_cnt == 3'h1) begin
          // Window expired without a store [R7] [R10] [R12] [R15]
          s.cmd   = `SPF_CMD_NONE;
          s.phase = SPF_IDLE;
        end else begin
          s.arm_cnt = q.arm_cnt - 3'h1;
        end
      end
      SPF_RUN: begin
        s.op_cnt = q.op_cnt - 1'b1;
        if (q.op_cnt == 1) begin
          // Command bits and store enable held until here [R7] [R10] [R12] [R15]
          s.cmd   = `SPF_CMD_NONE;
          s.halt  = 1'b0;
          s.op    = SPF_OP_NONE;
          s.phase = SPF_IDLE;
          if (q.op == SPF_OP_LOCK) begin
            // Only boot lock bits are reachable; cleared bits program [R6]
            s.lock_bits[5:2] = q.lock_bits[5:2] & q.lock_data[5:2];
          end
          if (q.op == SPF_OP_WRITE) begin
            s.buf_loaded = 1'b0;
          end
        end
      end
      default: begin
        s.phase = SPF_IDLE;
      end
    endcase

    // Register write wins over window bookkeeping of the same cycle
    if (ctrl_wr) begin
      s.irq_en = q.wdata[`SPF_BIT_IRQ_EN];
      // Busy flag is never written [R24]; command writes during an operation refused [R4]
      if ((q.phase != SPF_RUN) && !nvdata_write_busy && cmd_legal(q.wdata[4:0])) begin // [R16] [R23]
        if ((q.wdata[4:0] == `SPF_CMD_REEN) && q.buf_loaded) begin
          s.buf_mem    = '1; // [R5]
          s.buf_loaded = 1'b0;
        end
        s.cmd     = q.wdata[4:0];
        s.arm_cnt = `SPF_ARM_WINDOW; // [R15]
        s.phase   = SPF_ARMED;
      end
    end

    // Level held while store enable is clear [R1]
    s.irq        = q.irq_en && global_irq_enable && !q.cmd[0];
    s.boot_start = boot_start_of(boot_size_hi, boot_size_lo); // [R19]
    s.buf_word   = q.buf_mem[flash_buf_index]; // [R18]
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q           <= '0;
      q.buf_mem   <= '1;
      q.lock_bits <= `SPF_LOCK_RESET;
    end else begin
      q <= s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready     = !q.aw_got && !q.bvalid;
  assign s_axi_wready      = !q.w_got && !q.bvalid;
  assign s_axi_bvalid      = q.bvalid;
  assign s_axi_bresp       = q.bresp;
  assign s_axi_arready     = !q.rvalid;
  assign s_axi_rvalid      = q.rvalid;
  assign s_axi_rdata       = q.rdata;
  assign s_axi_rresp       = q.rresp;
  assign lpm_special_valid = q.lpm_valid;
  assign lpm_special_data  = q.lpm_data;
  assign ready_irq         = q.irq;
  assign cpu_halt          = q.halt;
  assign rw_section_busy   = q.rww_busy;
  assign boot_start_addr   = q.boot_start;
  assign lock_bits         = q.lock_bits;
  assign flash_erase_start = q.erase_pulse;
  assign flash_write_start = q.write_pulse;
  assign flash_lock_start  = q.lock_pulse;
  assign flash_page        = q.page;
  assign flash_lock_data   = q.lock_data;
  assign flash_buf_word    = q.buf_word;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_irq_level: assert property (q.irq_en && global_irq_enable && !q.cmd[0] |=> ready_irq) // [R1]
    else $error("ready interrupt not asserted");

  a_busy_on_rww: assert property (spm_go && (q.cmd == `SPF_CMD_WRITE) && (z_ptr[15:8] < `SPF_NO_READ_WHILE_WRITE_SECTION_PAGE)
    |=> rw_section_busy && !cpu_halt && flash_write_start) // [R2]
    else $error("busy flag not set by section write");

  a_load_clears: assert property (spm_go && !ctrl_wr && (q.cmd == `SPF_CMD_STORE) |=> !rw_section_busy && (q.cmd == 5'h00)) // [R3]
    else $error("buffer load did not clear busy");

  a_run_refuses: assert property ((q.phase == SPF_RUN) && (q.op_cnt > 1) |=> (q.cmd == $past(q.cmd))) // [R4]
    else $error("command changed during operation");

  a_abort_load: assert property (ctrl_wr && (q.wdata[4:0] == `SPF_CMD_REEN) && q.buf_loaded &&
    (q.phase != SPF_RUN) && !nvdata_write_busy |=> !q.buf_loaded && (q.buf_mem[0] == 16'hffff)) // [R5]
    else $error("buffer load not aborted");

  a_window_end: assert property ((q.phase == SPF_ARMED) && (q.arm_cnt == 3'h1) && !spm_go && !lpm_go && !ctrl_wr
    |=> (q.cmd == 5'h00) && (q.phase == SPF_IDLE)) // [R15]
    else $error("arming window did not expire");

  a_lpm_answer: assert property (lpm_go && (z_ptr[1:0] == `SPF_Z_LOCK)
    |=> lpm_special_valid && (lpm_special_data == {2'b11, $past(q.lock_bits[5:2]), 2'b11})) // [R8]
    else $error("lock readout wrong");

  a_halt_no_read_while_write_section: assert property (spm_go && (q.cmd == `SPF_CMD_ERASE) && (z_ptr[15:8] >= `SPF_NO_READ_WHILE_WRITE_SECTION_PAGE)
    |=> cpu_halt[*8]) // [R13]
    else $error("processor not halted for section erase");

  a_op_end: assert property ((q.phase == SPF_RUN) && (q.op_cnt == 1)
    |=> (q.phase == SPF_IDLE) && !cpu_halt && (q.cmd == 5'h00)) // [R22]
    else $error("operation did not end on count");

  a_nv_blocks: assert property (nvdata_write_busy && lpm_strobe |=> !lpm_special_valid) // [R23]
    else $error("readout during data-memory write");

  a_illegal_cmd: assert property (ctrl_wr && !cmd_legal(q.wdata[4:0]) && (q.phase == SPF_IDLE)
    |=> (q.phase == SPF_IDLE) && (q.cmd == 5'h00)) // [R16]
    else $error("illegal command took effect");

  a_busy_ro: assert property (ctrl_wr && !spm_strobe && (q.phase != SPF_RUN)
    |=> rw_section_busy == $past(rw_section_busy)) // [R24]
    else $error("busy flag changed by write");

endmodule // spf_ctrl

// ===== dv/spf_core_model.sv
// Core model: turns bench requests into one-cycle store and load strobes.
// Assumes the bench pulses go_spm or go_lpm for one cycle after a clock edge.
`timescale 1ns/1ps
module spf_core_model (
  // Clock and bench requests
  input  wire logic        aclk,
  input  wire logic        go_spm,
  input  wire logic        go_lpm,
  input  wire logic [15:0] z_in,
  input  wire logic [15:0] rr_in,
  // Controller side
  input  wire logic        cpu_halt,
  input  wire logic        lpm_special_valid,
  input  wire logic [7:0]  lpm_special_data,
  output logic             spm_strobe,
  output logic             lpm_strobe,
  output logic [15:0]      z_ptr,
  output logic [7:0]       r0_data,
  output logic [7:0]       r1_data,
  output logic [7:0]       lpm_result
);
  initial {spm_strobe, lpm_strobe, z_ptr, r0_data, r1_data, lpm_result} = '0;
  // Halted core issues nothing; operands toggle outside strobes
  always @(posedge aclk) begin
    spm_strobe <= go_spm && !cpu_halt;
    lpm_strobe <= go_lpm && !cpu_halt;
    {r1_data, r0_data} <= go_spm ? rr_in : ~{r1_data, r0_data};
    z_ptr <= (go_spm || go_lpm) ? z_in : ~z_ptr;
    if (lpm_special_valid) lpm_result <= lpm_special_data;
  end
endmodule // spf_core_model

// ===== dv/self_program_flash_control_tb.sv
// Bench for the flash controller: AXI4-Lite tasks plus a core model.
// Assumes PROG_CYCLES is shortened to 40 so operations end quickly.
`timescale 1ns/1ps
`include "spf_consts.svh"
module self_program_flash_control_tb;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, go_spm = 0, go_lpm = 0, global_irq_enable = 1;
  logic nvdata_write_busy = 0, boot_size_hi = 0, boot_size_lo = 0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [15:0] z_in = '0, rr_in = '0, z_ptr, flash_buf_word;
  logic [7:0] fuse_low = 8'h5a, fuse_high = 8'ha5, fuse_ext = 8'h3c;
  logic [6:0] flash_buf_index = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, spm_strobe, lpm_strobe;
  logic lpm_special_valid, ready_irq, cpu_halt, rw_section_busy;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] r0_data, r1_data, lpm_special_data, lock_bits, flash_page, lpm_result;
  logic [14:0] boot_start_addr;
  logic [14:0] bt[4] = '{`SPF_BOOT_4096, `SPF_BOOT_2048, `SPF_BOOT_1024, `SPF_BOOT_512};
  logic [7:0] lr[4] = '{8'h5a, 8'hc3, 8'h3c, 8'ha5};
  int n_mismatch = 0, checked = 0;

  spf_ctrl #(.PROG_CYCLES(40)) spf_ctrl_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .spm_strobe, .lpm_strobe, .z_ptr, .r0_data, .r1_data, .global_irq_enable, .nvdata_write_busy,
    .lpm_special_valid, .lpm_special_data, .ready_irq, .cpu_halt, .rw_section_busy, .boot_size_hi,
    .boot_size_lo, .fuse_low, .fuse_high, .fuse_ext, .boot_start_addr, .lock_bits,
    .flash_erase_start(), .flash_write_start(), .flash_lock_start(), .flash_page,
    .flash_lock_data(), .flash_buf_index, .flash_buf_word);

  spf_core_model spf_core_model_i (.aclk, .go_spm, .go_lpm, .z_in, .rr_in, .cpu_halt,
    .lpm_special_valid, .lpm_special_data, .spm_strobe, .lpm_strobe, .z_ptr, .r0_data,
    .r1_data, .lpm_result);

  // ----------------------------------------------------------------
  // Bus and core tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= `SPF_CTRL_ADDR;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 0;
    chk(s_axi_rdata, exp);
  endtask

  // Store when s is high, load otherwise
  task automatic op(input logic s, input logic [15:0] z, input logic [15:0] r);
    go_spm <= s;
    go_lpm <= !s;
    z_in <= z;
    rr_in <= r;
    @(posedge aclk);
    go_spm <= 0;
    go_lpm <= 0;
  endtask

  task automatic final_report;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial forever #12.5 aclk = ~aclk;
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    final_report;
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rchk(`SPF_CTRL_ADDR, 0);
    rchk(12'h06c, 0);
    chk(s_axi_rresp, `SPF_RESP_SLVERR);
    wr(8'h07);
    rchk(`SPF_CTRL_ADDR, 0);
    wr(8'hff);
    rchk(`SPF_CTRL_ADDR, 32'h80);
    for (int i = 0; i < 4; i++) begin
      {boot_size_hi, boot_size_lo} <= i[1:0];
      repeat (3) @(posedge aclk);
      chk(boot_start_addr, bt[i]);
    end
    wr(8'h81);
    @(posedge aclk);
    chk(ready_irq, 0);
    repeat (6) @(posedge aclk);
    chk(ready_irq, 1);
    wr(8'h00);
    $display("test registers done");
    wr(`SPF_CMD_STORE);
    op(1, 16'h0006, 16'h1234);
    flash_buf_index <= 7'h03;
    repeat (4) @(posedge aclk);
    chk(flash_buf_word, 16'h1234);
    rchk(`SPF_CTRL_ADDR, 0);
    wr(`SPF_CMD_REEN);
    repeat (3) @(posedge aclk);
    chk(flash_buf_word, 16'hffff);
    nvdata_write_busy <= 1;
    wr(`SPF_CMD_STORE);
    rchk(`SPF_CTRL_ADDR, 0);
    nvdata_write_busy <= 0;
    $display("test buffer done");
    wr(`SPF_CMD_ERASE);
    op(1, 16'h0100, 0);
    repeat (4) @(posedge aclk);
    chk(flash_page, 8'h01);
    rchk(`SPF_CTRL_ADDR, 32'h43);
    wr(`SPF_CMD_REEN);
    rchk(`SPF_CTRL_ADDR, 32'h43);
    repeat (50) @(posedge aclk);
    rchk(`SPF_CTRL_ADDR, 32'h40);
    wr(`SPF_CMD_REEN);
    op(1, 0, 0);
    rchk(`SPF_CTRL_ADDR, 0);
    wr(`SPF_CMD_WRITE);
    op(1, 16'h0300, 0);
    repeat (4) @(posedge aclk);
    chk(flash_page, 8'h03);
    repeat (50) @(posedge aclk);
    wr(`SPF_CMD_STORE);
    op(1, 0, 0);
    rchk(`SPF_CTRL_ADDR, 0);
    wr(`SPF_CMD_WRITE);
    repeat (6) @(posedge aclk);
    rchk(`SPF_CTRL_ADDR, 0);
    op(1, 16'h0200, 0);
    repeat (4) @(posedge aclk);
    chk(flash_page, 8'h03);
    wr(`SPF_CMD_ERASE);
    op(1, 16'he000, 0);
    repeat (4) @(posedge aclk);
    chk(cpu_halt, 1);
    repeat (50) @(posedge aclk);
    chk(cpu_halt, 0);
    rchk(`SPF_CTRL_ADDR, 0);
    $display("test erase write done");
    wr(`SPF_CMD_LOCK);
    op(1, 0, 16'h00c3);
    repeat (50) @(posedge aclk);
    chk(lock_bits, 8'hc3);
    rchk(`SPF_CTRL_ADDR, 0);
    for (int i = 0; i < 4; i++) begin
      wr(`SPF_CMD_LOCK);
      op(0, i[15:0], 0);
      repeat (4) @(posedge aclk);
      chk(lpm_result, lr[i]);
    end
    wr(`SPF_CMD_LOCK);
    nvdata_write_busy <= 1;
    op(0, 16'h0001, 0);
    repeat (4) @(posedge aclk);
    chk(lpm_result, lr[3]);
    nvdata_write_busy <= 0;
    $display("test lock done");
    final_report;
  end
endmodule // self_program_flash_control_tb
